//--- tb/dcc_analog_model.sv
`timescale 1ns/1ps
// analog core: raw result settles off the clock edge
module dcc_analog_model(input [1:0] vin_i, output [1:0] raw_o);
	assign #7 raw_o = vin_i;
endmodule // dcc_analog_model

//--- tb/dcc_assertions.sv
`timescale 1ns/1ps
module dcc_assertions(
	input sys_clk_i, reset_i, sfr_write_i, sfr_read_i, sfr_hit_o, cmp_reset_request_o,
	input [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
	input [1:0] cmp_enable_o, cmp_route_o, cmp_irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	a_route_off: assert property ((cmp_route_o & ~cmp_enable_o & ~$past(cmp_enable_o)) == 2'h0)
		else $error("route");
	a_irq_off: assert property ((cmp_irq_o & ~cmp_enable_o) == 2'h0) else $error("irq");
	a_reset_src: assert property (cmp_reset_request_o |-> cmp_enable_o[0] && !cmp_route_o[0])
		else $error("req");
	a_irq_hold: assert property (cmp_irq_o[0] && !sfr_write_i |=> cmp_irq_o[0])
		else $error("hold");
	a_read_idle: assert property (!$past(sfr_read_i) |-> sfr_rdata_o == 8'h00)
		else $error("rd");
	a_read_miss: assert property ($past(sfr_read_i && !sfr_hit_o) |-> sfr_rdata_o == 8'h00)
		else $error("miss");
	a_addr_map: assert property (sfr_hit_o == (sfr_addr_i[7:1] == 7'h4f))
		else $error("map");
	a_write_en: assert property (sfr_write_i && sfr_hit_o |=>
		cmp_enable_o[$past(sfr_addr_i[0])] == $past(sfr_wdata_i[7])) else $error("en");
endmodule // dcc_assertions
bind dcc_dual_comparator_control dcc_assertions dcc_assertions_i(.*);

//--- tb/dcc_dual_comparator_control_tb.sv
`timescale 1ns/1ps
module dcc_dual_comparator_control_tb;
	logic sys_clk_i = 0, reset_i = 1, sfr_write_i = 0, sfr_read_i = 0;
	logic sfr_hit_o, cmp_reset_request_o;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
	logic [3:0] cmp_pos_hysteresis_o, cmp_neg_hysteresis_o;
	logic [1:0] vin = 2'h0, cmp_raw_i, cmp_enable_o, cmp_route_o, cmp_irq_o;
	integer n_fail = 0, total_checks = 0, i;
	always #25 sys_clk_i = ~sys_clk_i;
	initial
	begin
		#9000 n_fail++;
		stop_test(0);
	end
	dcc_analog_model dcc_analog_model_i(.vin_i(vin), .raw_o(cmp_raw_i));
	dcc_dual_comparator_control dcc_dual_comparator_control_i(.*);
	task chk(input [7:0] g, e);
		total_checks++;
		n_fail += g !== e;
		if (g !== e) $display("ERROR %0t %h %h", $time, g, e);
	endtask
	// one-clock strobe, read data sampled after it
	task acc(input w, input [7:0] a, d);
		@(negedge sys_clk_i);
		{sfr_write_i, sfr_read_i, sfr_addr_i, sfr_wdata_i} = {w, !w, a, d};
		@(negedge sys_clk_i);
		{sfr_write_i, sfr_read_i} = 2'h0;
	endtask
	task stop_test(input integer x);
		if (n_fail + x == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task t_regs;
		acc(0, 8'h9d, 8'h00);
		chk(sfr_rdata_o, 8'h00);
		acc(1, 8'h9e, 8'hff);
		acc(0, 8'h9e, 8'h00);
		chk(sfr_rdata_o, 8'hbf);
		for (i = 0; i < 4; i++)
		begin
			acc(1, 8'h9f, i[7:0] * 8'h05);
			chk({cmp_pos_hysteresis_o[3:2], cmp_neg_hysteresis_o[3:2]}, i[7:0] * 8'h05);
		end
	endtask
	// rise, clear, fall on comparator 0
	task t_edge;
		acc(1, 8'h9e, 8'h80);
		vin = 2'h1;
		repeat (6) @(negedge sys_clk_i);
		chk({cmp_irq_o, cmp_route_o}, 8'h05);
		acc(0, 8'h9e, 8'h00);
		chk(sfr_rdata_o, 8'he0);
		acc(1, 8'h9e, 8'h80);
		vin = 2'h0;
		repeat (6) @(negedge sys_clk_i);
		acc(0, 8'h9e, 8'h00);
		chk(sfr_rdata_o, 8'h90);
		chk(cmp_reset_request_o, 8'h01);
	endtask
	// comparator 1 rises, then is disabled while high
	task t_cmp1;
		acc(1, 8'h9e, 8'h00);
		acc(1, 8'h9f, 8'h80);
		vin = 2'h3;
		repeat (6) @(negedge sys_clk_i);
		chk({cmp_enable_o, cmp_irq_o, cmp_route_o}, 8'h2a);
		chk(cmp_reset_request_o, 8'h00);
		acc(0, 8'h9f, 8'h00);
		chk(sfr_rdata_o, 8'he0);
		acc(1, 8'h9f, 8'h00);
		chk({cmp_route_o, cmp_irq_o}, 8'h00);
		acc(1, 8'h9e, 8'h06);
		chk({cmp_pos_hysteresis_o, cmp_neg_hysteresis_o}, 8'h12);
	endtask
	initial
	begin
		#200 reset_i = 0;
		t_regs;
		t_edge;
		t_cmp1;
		stop_test(0);
	end
endmodule // dcc_dual_comparator_control_tb

//--- verilog/dcc_dual_comparator_control.v
`timescale 1ns/1ps
// Function
// R1: enable bit 7 powers comparator up when 1, shuts it down when 0.
// R2: disabled comparator drives routed output low and raises no interrupts.
// R3: output state bit 6 reads comparator result at any time; the code reads it as 0 while the comparator is disabled.
// R4: rising output transition sets rise flag, bit 5.
// R5: falling output transition sets fall flag, bit 4.
// R6: edge flags stay set until software clears them.
// R7: interrupt request raised while any rise or fall flag is set; the code raises it only while the comparator is also enabled.
// R8: bits 3-2 select positive hysteresis: off, 2, 4, 10 mV.
// R9: bits 1-0 select negative hysteresis with same encoding.
// R10: comparator 0 can request system reset; comparator 1 cannot.
// R11: comparator 1 identical, controlled by its own register.
// R12: each output offered to crossbar for open-drain or push-pull pins.
// R13: raw comparator outputs pass two flip-flops before edge detection.
// R14: output bit is read-only; writing 0 clears flag; set beats clear.
`include "dcc_regs.vh"

module dcc_dual_comparator_control
(
	input wire sys_clk_i,
	input wire reset_i,
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	input wire sfr_write_i,
	input wire sfr_read_i,
	output reg [7:0] sfr_rdata_o,
	output wire sfr_hit_o,
	input wire [1:0] cmp_raw_i,
	output wire [1:0] cmp_enable_o,
	output wire [3:0] cmp_pos_hysteresis_o,
	output wire [3:0] cmp_neg_hysteresis_o,
	output wire [1:0] cmp_route_o,
	output wire [1:0] cmp_irq_o,
	output wire cmp_reset_request_o
);

	// =================================================================
	// slice count and field width
	localparam N_CMP = 2;
	localparam HYS_W = 2;

	// gathered per-comparator state
	wire [1:0] cmp_en;
	wire [1:0] cmp_state;
	wire [1:0] cmp_valid;
	wire [1:0] cmp_rise;
	wire [1:0] cmp_fall;
	wire [3:0] cmp_hys_p;
	wire [3:0] cmp_hys_n;

	// bus selects and edge events per comparator
	wire [1:0] wr_sel;
	wire [1:0] rd_sel;
	wire [1:0] live;
	wire [1:0] rise_evt;
	wire [1:0] fall_evt;

	// read data next value
	reg [7:0] next_rdata;

	// two-stage synchroniser for the raw comparator results
	reg [1:0] sync_a;
	reg [1:0] sync_b;

	// =================================================================
	// address decode shared by read and write
	function sel_of;
		input [7:0] addr;
		input integer idx;
		begin
			if (idx == 0)
				sel_of = (addr == `DCC_ADDR_CTRL0);
			else
				sel_of = (addr == `DCC_ADDR_CTRL1);
		end
	endfunction

	// control register layout, used for both comparators
	function [7:0] pack_ctrl;
		input en;
		input out;
		input rise;
		input fall;
		input [1:0] hyp;
		input [1:0] hyn;
		begin
			pack_ctrl = `DCC_CTRL_RESET;
			pack_ctrl[`DCC_BIT_ENABLE] = en;
			pack_ctrl[`DCC_BIT_OUTPUT] = out;
			pack_ctrl[`DCC_BIT_RISE] = rise;
			pack_ctrl[`DCC_BIT_FALL] = fall;
			pack_ctrl[`DCC_POS_HYS_HI:`DCC_POS_HYS_LO] = hyp;
			pack_ctrl[`DCC_NEG_HYS_HI:`DCC_NEG_HYS_LO] = hyn;
		end
	endfunction

	// =================================================================
	// register hit for the core
	assign sfr_hit_o = sel_of(sfr_addr_i, 0) | sel_of(sfr_addr_i, 1);

	// =================================================================
	// first synchroniser stage, read only by the second
	always @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			sync_a <= 2'h0;
		else
			sync_a <= cmp_raw_i; // R13
	end

	// second stage feeds all comparator logic
	always @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			sync_b <= 2'h0;
		else
			sync_b <= sync_a; // R13
	end

	// =================================================================
	// one slice per comparator
	genvar g;
	generate
		for (g = 0; g < N_CMP; g = g + 1)
		begin : g_cmp
			// register bits of this comparator
			reg enable;
			reg [HYS_W-1:0] pos_hys;
			reg [HYS_W-1:0] neg_hys;
			reg rise_flag;
			reg fall_flag;
			reg out_state;
			reg seen_enabled;
			reg route;
			// next values
			reg next_enable;
			reg [HYS_W-1:0] next_pos_hys;
			reg [HYS_W-1:0] next_neg_hys;
			reg next_rise;
			reg next_fall;

			// bus selects for this register
			assign wr_sel[g] = sfr_write_i & sel_of(sfr_addr_i, g); // R11
			assign rd_sel[g] = sfr_read_i & sel_of(sfr_addr_i, g); // R11

			// output seen by logic forced low while disabled
			assign live[g] = sync_b[g] & enable; // R2
			// edges only counted after one enabled cycle
			assign rise_evt[g] = enable & seen_enabled & live[g] & ~out_state; // R4
			assign fall_evt[g] = enable & seen_enabled & ~live[g] & out_state; // R5

			// next control fields from a write
			always @*
			begin
				next_enable = enable;
				next_pos_hys = pos_hys;
				next_neg_hys = neg_hys;
				if (wr_sel[g])
				begin
					next_enable = sfr_wdata_i[`DCC_BIT_ENABLE]; // R1
					next_pos_hys = sfr_wdata_i[`DCC_POS_HYS_HI:`DCC_POS_HYS_LO]; // R8
					next_neg_hys = sfr_wdata_i[`DCC_NEG_HYS_HI:`DCC_NEG_HYS_LO]; // R9
				end
			end

			// enable bit register
			always @(posedge sys_clk_i or posedge reset_i)
			begin
				if (reset_i)
					enable <= 1'b0;
				else
					enable <= next_enable; // R1
			end

			// hysteresis fields register
			always @(posedge sys_clk_i or posedge reset_i)
			begin
				if (reset_i)
				begin
					pos_hys <= 2'h0;
					neg_hys <= 2'h0;
				end
				else
				begin
					pos_hys <= next_pos_hys; // R8
					neg_hys <= next_neg_hys; // R9
				end
			end

			// comparator result as last sampled
			always @(posedge sys_clk_i or posedge reset_i)
			begin
				if (reset_i)
					out_state <= 1'b0;
				else
					out_state <= live[g]; // R3
			end

			// history of enable, gates the first edge
			always @(posedge sys_clk_i or posedge reset_i)
			begin
				if (reset_i)
					seen_enabled <= 1'b0;
				else
					seen_enabled <= enable;
			end

			// crossbar copy, dropped on the edge that disables
			always @(posedge sys_clk_i or posedge reset_i)
			begin
				if (reset_i)
					route <= 1'b0;
				else
					route <= sync_b[g] & next_enable; // R2
			end

			// next flags, hardware set wins over a clear
			always @*
			begin
				next_rise = rise_flag; // R6
				next_fall = fall_flag; // R6
				if (wr_sel[g])
				begin
					next_rise = sfr_wdata_i[`DCC_BIT_RISE]; // R14
					next_fall = sfr_wdata_i[`DCC_BIT_FALL]; // R14
				end
				if (rise_evt[g])
					next_rise = 1'b1; // R4
				if (fall_evt[g])
					next_fall = 1'b1; // R5
			end

			// rising-edge flag register
			always @(posedge sys_clk_i or posedge reset_i)
			begin
				if (reset_i)
					rise_flag <= 1'b0;
				else
					rise_flag <= next_rise; // R4
			end

			// falling-edge flag register
			always @(posedge sys_clk_i or posedge reset_i)
			begin
				if (reset_i)
					fall_flag <= 1'b0;
				else
					fall_flag <= next_fall; // R5
			end

			// gather control state into vectors
			assign cmp_en[g] = enable;
			assign cmp_hys_p[2*g+1:2*g] = pos_hys;
			assign cmp_hys_n[2*g+1:2*g] = neg_hys;
			// gather status into vectors
			assign cmp_state[g] = out_state;
			assign cmp_valid[g] = seen_enabled;
			assign cmp_rise[g] = rise_flag;
			assign cmp_fall[g] = fall_flag;

			// crossbar and interrupt request
			assign cmp_route_o[g] = route; // R12
			assign cmp_irq_o[g] = enable & (rise_flag | fall_flag); // R7
		end
	endgenerate

	// =================================================================
	// read multiplexer, zero when no register is read
	always @*
	begin
		next_rdata = 8'h00;
		case (rd_sel)
			2'b01: next_rdata = pack_ctrl(cmp_en[0], cmp_state[0], cmp_rise[0], cmp_fall[0],
				cmp_hys_p[1:0], cmp_hys_n[1:0]); // R3
			2'b10: next_rdata = pack_ctrl(cmp_en[1], cmp_state[1], cmp_rise[1], cmp_fall[1],
				cmp_hys_p[3:2], cmp_hys_n[3:2]); // R3
			default: next_rdata = 8'h00;
		endcase
	end

	// read data register, one cycle per read strobe
	// output bit is never written from the bus
	always @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			sfr_rdata_o <= `DCC_CTRL_RESET;
		else
			sfr_rdata_o <= next_rdata; // R3
	end

	// =================================================================
	// analog core controls
	assign cmp_enable_o = cmp_en; // R1
	assign cmp_pos_hysteresis_o = cmp_hys_p; // R8
	assign cmp_neg_hysteresis_o = cmp_hys_n; // R9

	// =================================================================
	// reset request from comparator 0 only; reset controller gates it
	// comparator 1 has no reset path at all
	assign cmp_reset_request_o = cmp_en[0] & cmp_valid[0] & ~cmp_state[0]; // R10

endmodule // dcc_dual_comparator_control

//--- verilog/dcc_regs.vh
`ifndef DCC_REGS_VH
`define DCC_REGS_VH
// =====================================================================
// register addresses on the special function register bus
`define DCC_ADDR_CTRL0 8'h9e
`define DCC_ADDR_CTRL1 8'h9f
// =====================================================================
// control register field positions
`define DCC_BIT_ENABLE 7
`define DCC_BIT_OUTPUT 6
`define DCC_BIT_RISE 5
`define DCC_BIT_FALL 4
`define DCC_POS_HYS_HI 3
`define DCC_POS_HYS_LO 2
`define DCC_NEG_HYS_HI 1
`define DCC_NEG_HYS_LO 0
// =====================================================================
// reset values
`define DCC_CTRL_RESET 8'h00
// =====================================================================
// hysteresis encodings
`define DCC_HYS_OFF 2'h0
`define DCC_HYS_2MV 2'h1
`define DCC_HYS_4MV 2'h2
`define DCC_HYS_10MV 2'h3
`endif
